// File: design/art_pkg.sv
package art_pkg;

  // Register indices. They are not all multiples of four, so each one is an index
  // and the Wishbone byte address is four times the index.
  localparam logic [7:0] ART_IDX_DUTY3 = 8'h73;
  localparam logic [7:0] ART_IDX_DUTY2 = 8'h74;
  localparam logic [7:0] ART_IDX_DUTY1 = 8'h75;
  localparam logic [7:0] ART_IDX_DUTY0 = 8'h76;
  localparam logic [7:0] ART_IDX_PWMCTL = 8'h77;
  localparam logic [7:0] ART_IDX_CSR = 8'h78;
  localparam logic [7:0] ART_IDX_CNT = 8'h79;
  localparam logic [7:0] ART_IDX_RELOAD = 8'h7A;
  localparam logic [7:0] ART_IDX_CAPCSR = 8'h7B;
  localparam logic [7:0] ART_IDX_CAP1 = 8'h7C;
  localparam logic [7:0] ART_IDX_CAP2 = 8'h7D;

  // Every register resets to zero.
  localparam logic [7:0] ART_RST_VAL = 8'h00;

  // Timer control/status field positions.
  localparam int ART_CSR_EXT = 7;
  localparam int ART_CSR_CC_HI = 6;
  localparam int ART_CSR_CC_LO = 4;
  localparam int ART_CSR_TCE = 3;
  localparam int ART_CSR_FRL = 2;
  localparam int ART_CSR_OIE = 1;
  localparam int ART_CSR_OVF = 0;

  // Capture control/status field positions.
  localparam int ART_CAP_CS_LO = 4;
  localparam int ART_CAP_CIE_LO = 2;
  localparam int ART_CAP_CF_LO = 0;

  // PWM control field positions.
  localparam int ART_PWM_OE_LO = 4;
  localparam int ART_PWM_OP_LO = 0;

  // Counter top value and prescaler width.
  localparam logic [7:0] ART_CNT_MAX = 8'hFF;
  localparam int ART_PRE_W = 7;

  // Bus request carried as one bundle.
  typedef struct packed {
    logic [7:0] idx;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } art_req_t;

endpackage

// File: design/art_timer.sv
`timescale 1ns/10ps
// Operation
// - Overflow interrupt requested when flag and enable set.
// - Overflow flag cleared by reading control/status.
// - Overflow flag set on FF to reload passage.
// - Counter readable and writable while running.
// - Overflow reloads counter and sets polarity levels.
// - Reload zero gives full eight-bit resolution.
// - Output enable bits connect channels to pins.
// - Output high at or below compare, polarity inverts.
// - Polarity change inverts output immediately (here the registered pin changes one edge after the write).
// - Duty register sets second edge via compare.
// - Capture status bits 7:6 read zero.
// - Edge select: zero falling, one rising.
// - Capture interrupt enables gate each flag.
// - Capture flag cleared by reading capture register.
// - Capture latches counter; writes ignored.
// - All registers reset to zero.
// - PWM frequency is counter clock over 256-reload.
// - Compare registers reload from duty on overflow.
// - Prescale field divides by two to power.
// - Force reload loads counter, clears prescaler, reads zero.
module art_timer
  import art_pkg::*;
#(
  parameter int NUM_CH = 4
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Classic Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // External count clock and capture pins, asynchronous.
  input wire logic ext_clk_pin,
  input wire logic [1:0] capture_input_pin,
  // PWM pins: value and active-low output enable.
  output logic [NUM_CH-1:0] pwm_output_pin,
  output logic [NUM_CH-1:0] pwm_output_pin_oe_n,
  // Combined interrupt request.
  output logic irq_r
);

  // The register layout has exactly four duty registers.
  initial
  begin
    if (NUM_CH != 4)
    begin
      $error("art_timer supports exactly four channels");
    end
  end

  // Register state.
  logic [7:0] duty_r [NUM_CH];
  logic [7:0] cmp_r [NUM_CH];
  logic [7:0] pwmctl_r;
  logic [2:0] prescale_select_r;
  logic external_clock_select_r;
  logic count_enable_bit_r;
  logic overflow_irq_enable_r;
  logic overflow_flag_r;
  logic [7:0] cnt_r;
  logic [7:0] reload_r;
  logic [1:0] cap_sens_r;
  logic [1:0] capture_irq_enables_r;
  logic [1:0] capture_flags_r;
  logic [7:0] cap_r [2];
  logic [ART_PRE_W-1:0] pre_r;
  logic [NUM_CH-1:0] pwm_lvl_r;

  // Synchronisers and previous samples.
  logic ext_s1_r, ext_s2_r, ext_prev_r;
  logic [1:0] cap_s1_r, cap_s2_r, cap_prev_r;

  // Bus decode.
  art_req_t req;
  logic acc;
  logic wr_strobe;
  logic rd_strobe;
  logic [7:0] rdata_nxt;

  // Decode of one register index, shared by every write and read strobe.
  function automatic logic hit(input art_req_t r, input logic [7:0] idx);
    hit = (r.idx == idx);
  endfunction

  // One-cycle ack per request; the ack register gaps back-to-back cycles.
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign req.idx = wb_adr_i[9:2];
  assign req.wr = acc && wb_we_i && wb_sel_i[0];
  assign req.rd = acc && !wb_we_i;
  assign req.wdata = wb_dat_i[7:0];
  assign wr_strobe = req.wr;
  assign rd_strobe = req.rd;

  // Tick from the selected count source. External edges are rising edges after two flops.
  logic src_tick;
  logic cnt_tick;
  logic [ART_PRE_W-1:0] pre_mask;
  assign src_tick = external_clock_select_r ? (ext_s2_r && !ext_prev_r) : 1'b1;
  // Divide by 2**select: tick when the low select bits of the prescaler are all ones.
  assign pre_mask = ART_PRE_W'((8'h01 << prescale_select_r) - 8'h01);
  assign cnt_tick = count_enable_bit_r && src_tick && ((pre_r & pre_mask) == pre_mask);

  logic ovf_evt;
  logic frl_wr;
  logic cnt_wr;
  assign ovf_evt = cnt_tick && (cnt_r == ART_CNT_MAX);
  assign frl_wr = wr_strobe && hit(req, ART_IDX_CSR) && req.wdata[ART_CSR_FRL];
  assign cnt_wr = wr_strobe && hit(req, ART_IDX_CNT);

  // Capture edge events with per-channel sensitivity.
  logic [1:0] cap_evt;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_cap_edge
      // Compare synchronised sample with previous one.
      assign cap_evt[gi] = cap_sens_r[gi] ? (cap_s2_r[gi] && !cap_prev_r[gi])
                                          : (!cap_s2_r[gi] && cap_prev_r[gi]);
    end
  endgenerate

  // Synchronisers; first stage is read only by the second.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_prev_r <= 1'b0;
      cap_s1_r <= 2'h0;
      cap_s2_r <= 2'h0;
      cap_prev_r <= 2'h0;
    end
    else
    begin
      ext_s1_r <= ext_clk_pin;
      ext_s2_r <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
      cap_s1_r <= capture_input_pin;
      cap_s2_r <= cap_s1_r;
      cap_prev_r <= cap_s2_r;
    end
  end

  // Prescaler: advances on each source tick while enabled, cleared by force reload and counter writes.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_r <= '0;
    end
    else if (frl_wr || cnt_wr)
    begin
      pre_r <= '0;
    end
    else if (count_enable_bit_r && src_tick)
    begin
      pre_r <= pre_r + 1'b1;
    end
  end

  // Counter: software write wins, then force reload, then overflow reload, then count.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= ART_RST_VAL;
    end
    else if (cnt_wr)
    begin
      cnt_r <= req.wdata;
    end
    else if (frl_wr)
    begin
      cnt_r <= reload_r;
    end
    else if (ovf_evt)
    begin
      cnt_r <= reload_r;
    end
    else if (cnt_tick)
    begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // Timer control/status; the overflow flag set beats the read clear.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      external_clock_select_r <= 1'b0;
      prescale_select_r <= 3'h0;
      count_enable_bit_r <= 1'b0;
      overflow_irq_enable_r <= 1'b0;
      overflow_flag_r <= 1'b0;
    end
    else
    begin
      if (wr_strobe && hit(req, ART_IDX_CSR))
      begin
        external_clock_select_r <= req.wdata[ART_CSR_EXT];
        prescale_select_r <= req.wdata[ART_CSR_CC_HI:ART_CSR_CC_LO];
        count_enable_bit_r <= req.wdata[ART_CSR_TCE];
        overflow_irq_enable_r <= req.wdata[ART_CSR_OIE];
      end
      if (ovf_evt)
      begin
        overflow_flag_r <= 1'b1;
      end
      else if (rd_strobe && hit(req, ART_IDX_CSR))
      begin
        overflow_flag_r <= 1'b0;
      end
    end
  end

  // Reload, PWM control and capture control writes.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reload_r <= ART_RST_VAL;
      pwmctl_r <= ART_RST_VAL;
      cap_sens_r <= 2'h0;
      capture_irq_enables_r <= 2'h0;
    end
    else if (wr_strobe)
    begin
      if (hit(req, ART_IDX_RELOAD))
      begin
        reload_r <= req.wdata;
      end
      if (hit(req, ART_IDX_PWMCTL))
      begin
        pwmctl_r <= req.wdata;
      end
      if (hit(req, ART_IDX_CAPCSR))
      begin
        cap_sens_r <= req.wdata[ART_CAP_CS_LO +: 2];
        capture_irq_enables_r <= req.wdata[ART_CAP_CIE_LO +: 2];
      end
    end
  end

  // Per-channel duty, hidden compare and raw waveform level.
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_pwm
      localparam logic [7:0] DUTY_IDX = ART_IDX_DUTY0 - 8'(gi);
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          duty_r[gi] <= ART_RST_VAL;
          cmp_r[gi] <= ART_RST_VAL;
          pwm_lvl_r[gi] <= 1'b0;
        end
        else
        begin
          if (wr_strobe && hit(req, DUTY_IDX))
          begin
            duty_r[gi] <= req.wdata;
          end
          if (ovf_evt)
          begin
            // Double buffering keeps duty changes glitch free.
            cmp_r[gi] <= duty_r[gi];
            pwm_lvl_r[gi] <= 1'b1;
          end
          else if (cnt_tick && (cnt_r == cmp_r[gi]))
          begin
            // Counter leaves the at-or-below region: level drops.
            pwm_lvl_r[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Pin drive. Polarity is applied on the registered output so a change shows next edge.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwm_output_pin <= '0;
      pwm_output_pin_oe_n <= '1;
    end
    else
    begin
      pwm_output_pin <= pwm_lvl_r ^ pwmctl_r[ART_PWM_OP_LO +: NUM_CH];
      pwm_output_pin_oe_n <= ~pwmctl_r[ART_PWM_OE_LO +: NUM_CH];
    end
  end

  // Capture flags and data; data is locked while its flag is set, up to the cycle of the clearing read.
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_cap
      localparam logic [7:0] CAP_IDX = ART_IDX_CAP1 + 8'(gi);
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          capture_flags_r[gi] <= 1'b0;
          cap_r[gi] <= ART_RST_VAL;
        end
        else if (cap_evt[gi] && (!capture_flags_r[gi] || (rd_strobe && hit(req, CAP_IDX))))
        begin
          // An edge in the cycle of the clearing read wins; that read returns the old data.
          capture_flags_r[gi] <= 1'b1;
          cap_r[gi] <= cnt_r;
        end
        else if (rd_strobe && hit(req, CAP_IDX))
        begin
          capture_flags_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Read mux.
  always_comb
  begin
    rdata_nxt = 8'h00;
    case (req.idx)
      ART_IDX_DUTY3: rdata_nxt = duty_r[3];
      ART_IDX_DUTY2: rdata_nxt = duty_r[2];
      ART_IDX_DUTY1: rdata_nxt = duty_r[1];
      ART_IDX_DUTY0: rdata_nxt = duty_r[0];
      ART_IDX_PWMCTL: rdata_nxt = pwmctl_r;
      // Force reload reads as zero.
      ART_IDX_CSR: rdata_nxt = {external_clock_select_r, prescale_select_r,
                                count_enable_bit_r, 1'b0, overflow_irq_enable_r,
                                overflow_flag_r};
      ART_IDX_CNT: rdata_nxt = cnt_r;
      ART_IDX_RELOAD: rdata_nxt = reload_r;
      ART_IDX_CAPCSR: rdata_nxt = {2'b00, cap_sens_r, capture_irq_enables_r,
                                   capture_flags_r};
      ART_IDX_CAP1: rdata_nxt = cap_r[0];
      ART_IDX_CAP2: rdata_nxt = cap_r[1];
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Bus answer: ack one cycle after the request, data registered alongside.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= acc;
      wb_dat_o <= req.rd ? {24'h000000, rdata_nxt} : 32'h0000_0000;
    end
  end

  // Interrupt request from any enabled flag.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= (overflow_flag_r && overflow_irq_enable_r)
               || |(capture_flags_r & capture_irq_enables_r);
    end
  end

endmodule

// File: verification/art_timer_properties.sv
`timescale 1ns/10ps
module art_chk
  import art_pkg::*;
#(
  parameter int NUM_CH = 4
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Bus side.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins.
  input wire logic ext_clk_pin,
  input wire logic [1:0] capture_input_pin,
  input wire logic [NUM_CH-1:0] pwm_output_pin,
  input wire logic [NUM_CH-1:0] pwm_output_pin_oe_n,
  input wire logic irq_r
);
  // One clock domain, so one default clock and reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Register index and a read answer, named once for the checks below.
  logic [7:0] idx;
  logic rd_ack;
  assign idx = wb_adr_i[9:2];
  assign rd_ack = wb_ack_o && !wb_we_i;

  property p_ack_lat;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_rsvd;
    rd_ack && idx == ART_IDX_CAPCSR |-> wb_dat_o[7:6] == 2'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("capture status top bits set");
  property p_frl;
    rd_ack && idx == ART_IDX_CSR |-> !wb_dat_o[ART_CSR_FRL];
  endproperty
  a_frl: assert property (p_frl) else $error("force reload reads one");
  // The enables written at the taking edge reach the pins at the next edge and are sampled there two edges later.
  property p_oe;
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && idx == ART_IDX_PWMCTL
      |-> ##2 pwm_output_pin_oe_n == ~$past(wb_dat_i[7:4], 2);
  endproperty
  a_oe: assert property (p_oe) else $error("output enables wrong");
  // Flags only clear through the bus, so the request falls only near an answer.
  property p_irq_fall;
    $fell(irq_r) |-> wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
  property p_rst;
    $rose(rst_n) |-> !irq_r && pwm_output_pin == '0 && pwm_output_pin_oe_n == '1;
  endproperty
  a_rst: assert property (p_rst) else $error("pins not at reset level");
  property p_hole;
    rd_ack && (idx < ART_IDX_DUTY3 || idx > ART_IDX_CAP2) |-> wb_dat_o == 32'h0;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
endmodule

// File: verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  import art_pkg::*;
  // Bus drive; stb follows cyc.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] dat = 32'h0;
  // Capture pins; ch2 starts high so it can fall.
  logic [1:0] cap = 2'h2;
  // External count source pin.
  logic ext = 1'b0;
  // Design outputs.
  logic [31:0] rdat;
  logic ack;
  logic [3:0] pin;
  logic [3:0] oe_n;
  logic irq;
  logic [7:0] v;
  int num_errors = 0;
  int tests_run = 0;
  int hi [4];

  art_timer #(.NUM_CH(4)) DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ext_clk_pin(ext), .capture_input_pin(cap), .pwm_output_pin(pin),
    .pwm_output_pin_oe_n(oe_n), .irq_r(irq));

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  // Counts, verdict and the end of the run.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compare and report.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask

  // One classic cycle, held until ack is seen at an edge; an idle edge follows.
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= {i, 2'h0};
    dat <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    v = rdat[7:0];
    cyc <= 1'b0;
    @(posedge clk);
    if (n >= 50)
    begin
      num_errors++;
      end_sim();
    end
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk($sformatf("reg %h", i), {8'h00, e}, {8'h00, v});
  endtask

  // Bounded wait for a level on the interrupt request.
  task automatic wait_irq(input logic l);
    int n;
    n = 0;
    while (irq !== l && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk("irq", {15'h0, l}, {15'h0, irq});
    if (n >= 3000)
    begin
      num_errors++;
      end_sim();
    end
  endtask

  // High cycles of each pin over a window that spans whole periods.
  task automatic cnt_hi(input int len);
    for (int c = 0; c < 4; c++) hi[c] = 0;
    repeat (len)
    begin
      @(posedge clk);
      for (int c = 0; c < 4; c++) if (pin[c] === 1'b1) hi[c]++;
    end
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 8'h72; i <= 8'h7D; i++) rd(8'(i), 8'h00);
    bus(1'b1, ART_IDX_CNT, 8'h5A);
    rd(ART_IDX_CNT, 8'h5A);
    bus(1'b1, ART_IDX_RELOAD, 8'hF0);
    bus(1'b1, ART_IDX_CSR, 8'h04);
    rd(ART_IDX_CNT, 8'hF0);
    rd(ART_IDX_CSR, 8'h00);
    // Duty of channel c is reload plus c, so c+1 high ticks in each 16.
    for (int c = 0; c < 4; c++) bus(1'b1, ART_IDX_DUTY0 - 8'(c), 8'hF0 + 8'(c));
    bus(1'b1, ART_IDX_PWMCTL, 8'h50);
    chk("oe_n", 16'h000A, {12'h0, oe_n});
    bus(1'b1, ART_IDX_PWMCTL, 8'hF0);
    for (int n = 0; n < 4; n++)
    begin
      bus(1'b1, ART_IDX_CSR, 8'(n << 4) | 8'h08);
      repeat (40 << n) @(posedge clk);
      cnt_hi(32 << n);
      for (int c = 0; c < 4; c++) chk("high", 16'((2 * c + 2) << n), 16'(hi[c]));
    end
    chk("irq masked", 16'h0, {15'h0, irq});
    bus(1'b1, ART_IDX_PWMCTL, 8'hFF);
    cnt_hi(256);
    for (int c = 0; c < 4; c++) chk("inv", 16'(256 - ((2 * c + 2) << 3)), 16'(hi[c]));
    bus(1'b1, ART_IDX_CSR, 8'h00);
    rd(ART_IDX_CSR, 8'h01);
    rd(ART_IDX_CSR, 8'h00);
    bus(1'b1, ART_IDX_CNT, 8'hFE);
    bus(1'b1, ART_IDX_CSR, 8'h0A);
    wait_irq(1'b1);
    bus(1'b1, ART_IDX_CSR, 8'h02);
    rd(ART_IDX_CSR, 8'h03);
    wait_irq(1'b0);
    // Stopped counter gives a known value to capture.
    bus(1'b1, ART_IDX_CNT, 8'h33);
    bus(1'b1, ART_IDX_CAPCSR, 8'h14);
    cap[0] <= 1'b1;
    wait_irq(1'b1);
    rd(ART_IDX_CAPCSR, 8'h15);
    rd(ART_IDX_CAP1, 8'h33);
    rd(ART_IDX_CAPCSR, 8'h14);
    cap[0] <= 1'b0;
    repeat (8) @(posedge clk);
    rd(ART_IDX_CAPCSR, 8'h14);
    bus(1'b1, ART_IDX_CNT, 8'h44);
    cap[1] <= 1'b0;
    repeat (8) @(posedge clk);
    rd(ART_IDX_CAPCSR, 8'h16);
    chk("irq cap2", 16'h0, {15'h0, irq});
    bus(1'b1, ART_IDX_CAP2, 8'hFF);
    rd(ART_IDX_CAP2, 8'h44);
    bus(1'b1, ART_IDX_CAPCSR, 8'hFF);
    rd(ART_IDX_CAPCSR, 8'h3C);
    // External count source: five rising edges on the pin give five counts.
    bus(1'b1, ART_IDX_CNT, 8'h10);
    bus(1'b1, ART_IDX_CSR, 8'h88);
    repeat (5)
    begin
      ext <= 1'b1;
      repeat (4) @(posedge clk);
      ext <= 1'b0;
      repeat (4) @(posedge clk);
    end
    rd(ART_IDX_CNT, 8'h15);
    // A reset in mid-run returns every written register to zero.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 8'h73; i <= 8'h7D; i++) rd(8'(i), 8'h00);
    end_sim();
  end
endmodule

bind art_timer art_chk #(.NUM_CH(NUM_CH)) u_chk (.clk(clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .ext_clk_pin(ext_clk_pin), .capture_input_pin(capture_input_pin),
  .pwm_output_pin(pwm_output_pin), .pwm_output_pin_oe_n(pwm_output_pin_oe_n), .irq_r(irq_r));
